/* design/wsm_core.sv */
// Windowed service monitor: APB registers, time-out counter, feed check, fault handling
`timescale 1ns/1ps
module wsm_core
#(
	parameter int unsigned CW = wsm_pkg::WSM_CW
)
(
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_ce,
	input wire logic i_irc_osc,
	input wire logic i_lp_osc,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [wsm_pkg::WSM_AW-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic o_irq,
	output logic o_chip_reset
);
	wsm_pkg::wsm_ctrl_t ctrl_r;
	wsm_pkg::wsm_ctrl_t ctrl_nxt;
	wsm_pkg::wsm_evt_t status_r;
	wsm_pkg::wsm_evt_t status_nxt;
	wsm_pkg::wsm_evt_t mask_r;
	wsm_pkg::wsm_evt_t mask_nxt;
	wsm_pkg::wsm_evt_t ev_set;
	logic [CW-1:0] tc_r;
	logic [CW-1:0] tc_nxt;
	logic [CW-1:0] warn_r;
	logic [CW-1:0] warn_nxt;
	logic [CW-1:0] win_r;
	logic [CW-1:0] win_nxt;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic armed_r;
	logic armed_nxt;
	logic pready_nxt;
	logic pslverr_nxt;
	logic [31:0] prdata_nxt;
	logic irq_nxt;
	logic chip_rst_nxt;
	logic tick;
	logic wr;
	logic feed_wr;
	logic key1;
	logic key2;
	logic good_feed;
	logic bad_feed;
	logic win_bad;
	logic timeout;
	logic fault;
	logic warn_evt;

	function automatic logic reg_hit(input logic [wsm_pkg::WSM_AW-1:0] a);
		reg_hit = (a == wsm_pkg::WSM_OFF_CTRL) || (a == wsm_pkg::WSM_OFF_TIMEOUT)
			|| (a == wsm_pkg::WSM_OFF_FEED) || (a == wsm_pkg::WSM_OFF_COUNT)
			|| (a == wsm_pkg::WSM_OFF_STATUS) || (a == wsm_pkg::WSM_OFF_MASK)
			|| (a == wsm_pkg::WSM_OFF_WARN) || (a == wsm_pkg::WSM_OFF_WINDOW);
	endfunction

	wsm_tick_gen u_tick
	(
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_ce(i_ce),
		.i_sel(ctrl_r.clk_sel),
		.i_irc_osc(i_irc_osc),
		.i_lp_osc(i_lp_osc),
		.o_tick(tick)
	);

	// Bus slave: one wait state, so every read and write ends on the second access cycle
	always_comb
	begin
		pready_nxt = i_psel && i_penable && !o_pready;
		pslverr_nxt = pready_nxt && !reg_hit(i_paddr);
		prdata_nxt = 32'h0;
		if (pready_nxt && !i_pwrite)
		begin
			unique case (i_paddr)
				wsm_pkg::WSM_OFF_CTRL: prdata_nxt = {27'h0, ctrl_r};
				wsm_pkg::WSM_OFF_TIMEOUT: prdata_nxt = {8'h0, tc_r};
				wsm_pkg::WSM_OFF_COUNT: prdata_nxt = {8'h0, cnt_r};
				wsm_pkg::WSM_OFF_STATUS: prdata_nxt = {29'h0, status_r};
				wsm_pkg::WSM_OFF_MASK: prdata_nxt = {29'h0, mask_r};
				wsm_pkg::WSM_OFF_WARN: prdata_nxt = {8'h0, warn_r};
				wsm_pkg::WSM_OFF_WINDOW: prdata_nxt = {8'h0, win_r};
				default: prdata_nxt = 32'h0;
			endcase
		end
	end

	// Feed check and fault sources
	always_comb
	begin
		wr = i_psel && i_penable && o_pready && i_pwrite;
		feed_wr = wr && (i_paddr == wsm_pkg::WSM_OFF_FEED);
		key1 = (i_pwdata[7:0] == wsm_pkg::WSM_FEED_KEY1);
		key2 = (i_pwdata[7:0] == wsm_pkg::WSM_FEED_KEY2);
		good_feed = ctrl_r.en && feed_wr && armed_r && key2;
		bad_feed = ctrl_r.en && feed_wr && !(armed_r && key2) && !(!armed_r && key1);
		win_bad = good_feed && ctrl_r.win_en && (cnt_r > win_r);
		timeout = ctrl_r.en && tick && (cnt_r == '0);
		fault = bad_feed || win_bad || timeout;
		warn_evt = ctrl_r.en && ctrl_r.warn_en && tick && !good_feed && !fault
			&& (cnt_r != '0) && ((cnt_r - 24'h000001) == warn_r);
		if (feed_wr)
		begin
			armed_nxt = !armed_r && key1;
		end
		else
		begin
			armed_nxt = armed_r;
		end
	end

	// Counter, control and configuration registers
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		tc_nxt = tc_r;
		warn_nxt = warn_r;
		win_nxt = win_r;
		mask_nxt = mask_r;
		cnt_nxt = cnt_r;
		if (wr)
		begin
			unique case (i_paddr)
				wsm_pkg::WSM_OFF_CTRL: ctrl_nxt = wsm_pkg::wsm_ctrl_t'({i_pwdata[4:1], i_pwdata[0] | ctrl_r.en});
				wsm_pkg::WSM_OFF_TIMEOUT:
					tc_nxt = (i_pwdata[23:0] < wsm_pkg::WSM_TIMEOUT_MIN) ? wsm_pkg::WSM_TIMEOUT_MIN : i_pwdata[23:0];
				wsm_pkg::WSM_OFF_MASK: mask_nxt = wsm_pkg::wsm_evt_t'(i_pwdata[2:0]);
				wsm_pkg::WSM_OFF_WARN: warn_nxt = i_pwdata[23:0];
				wsm_pkg::WSM_OFF_WINDOW: win_nxt = i_pwdata[23:0];
				default: ctrl_nxt = ctrl_r;
			endcase
		end
		if (fault)
		begin
			ctrl_nxt.en = 1'b0;
		end
		// A stopped counter tracks the time-out so enabling starts from a full period
		if (!ctrl_r.en || fault || good_feed)
		begin
			cnt_nxt = tc_r;
		end
		else if (tick)
		begin
			cnt_nxt = cnt_r - 24'h000001;
		end
	end

	// Sticky events, write one to clear; a new event wins over its clear
	always_comb
	begin
		ev_set.rst_flag = fault && ctrl_r.rst_en;
		ev_set.fault = fault && !ctrl_r.rst_en;
		ev_set.warn = warn_evt;
		status_nxt = status_r;
		if (wr && (i_paddr == wsm_pkg::WSM_OFF_STATUS))
		begin
			status_nxt = status_r & ~wsm_pkg::wsm_evt_t'(i_pwdata[2:0]);
		end
		status_nxt = status_nxt | ev_set;
		irq_nxt = |(status_nxt & mask_nxt);
		chip_rst_nxt = fault && ctrl_r.rst_en;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			ctrl_r <= '0;
			tc_r <= wsm_pkg::WSM_TIMEOUT_RST;
			warn_r <= wsm_pkg::WSM_WARN_RST;
			win_r <= wsm_pkg::WSM_WINDOW_RST;
			mask_r <= wsm_pkg::WSM_MASK_RST;
			status_r <= '0;
			cnt_r <= wsm_pkg::WSM_TIMEOUT_RST;
			armed_r <= 1'b0;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h0;
			o_irq <= 1'b0;
			o_chip_reset <= 1'b0;
		end
		else if (i_ce)
		begin
			ctrl_r <= ctrl_nxt;
			tc_r <= tc_nxt;
			warn_r <= warn_nxt;
			win_r <= win_nxt;
			mask_r <= mask_nxt;
			status_r <= status_nxt;
			cnt_r <= cnt_nxt;
			armed_r <= armed_nxt;
			o_pready <= pready_nxt;
			o_pslverr <= pslverr_nxt;
			o_prdata <= prdata_nxt;
			o_irq <= irq_nxt;
			o_chip_reset <= chip_rst_nxt;
		end
	end

	default clocking cb_core @(posedge i_mclk);
	endclocking
	default disable iff (i_reset);

	property p_timeout_reset;
		i_ce && ctrl_r.en && ctrl_r.rst_en && tick && (cnt_r == '0) |=> o_chip_reset && !ctrl_r.en;
	endproperty
	a_timeout_reset: assert property (p_timeout_reset) else $error("time-out without chip reset");

	property p_window_early;
		i_ce && good_feed && ctrl_r.win_en && (cnt_r > win_r) |=> !ctrl_r.en && (cnt_r == tc_r);
	endproperty
	a_window_early: assert property (p_window_early) else $error("early reload not treated as fault");

	property p_warn_irq;
		i_ce && warn_evt && mask_r.warn && !(wr && (i_paddr == wsm_pkg::WSM_OFF_MASK)) |=> o_irq && status_r.warn;
	endproperty
	a_warn_irq: assert property (p_warn_irq) else $error("warning not raised");

	property p_no_sw_disable;
		ctrl_r.en && !fault |=> ctrl_r.en;
	endproperty
	a_no_sw_disable: assert property (p_no_sw_disable) else $error("enable dropped without fault");

	property p_bad_feed;
		i_ce && bad_feed && !ctrl_r.rst_en |=> status_r.fault && !o_chip_reset;
	endproperty
	a_bad_feed: assert property (p_bad_feed) else $error("bad feed not flagged");

	property p_reset_flag;
		o_chip_reset |-> status_r.rst_flag;
	endproperty
	a_reset_flag: assert property (p_reset_flag) else $error("chip reset without flag");

	property p_count_step;
		i_ce && ctrl_r.en && !tick && !good_feed && !fault |=> cnt_r == $past(cnt_r);
	endproperty
	a_count_step: assert property (p_count_step) else $error("counter moved without tick");

	property p_reload;
		i_ce && good_feed && !win_bad ##1 i_ce && !tick |=> cnt_r == tc_r;
	endproperty
	a_reload: assert property (p_reload) else $error("reload did not restore time-out");

	property p_tc_floor;
		tc_r >= wsm_pkg::WSM_TIMEOUT_MIN;
	endproperty
	a_tc_floor: assert property (p_tc_floor) else $error("time-out below minimum");

	c_timeout: cover property (timeout && ctrl_r.rst_en);
	c_good_feed: cover property (good_feed);
	c_warn: cover property (warn_evt);
	c_fault_irq: cover property (fault && !ctrl_r.rst_en);
endmodule

/* design/wsm_tick_gen.sv */
// Watchdog tick source: oscillator select, synchronisers and divide-by-four prescaler
`timescale 1ns/1ps
module wsm_tick_gen
(
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_ce,
	input wire logic i_sel,
	input wire logic i_irc_osc,
	input wire logic i_lp_osc,
	output logic o_tick
);
	logic [1:0] sync1_r;
	logic [1:0] sync2_r;
	logic [1:0] sync1_nxt;
	logic [1:0] sync2_nxt;
	logic prev_r;
	logic prev_nxt;
	logic [1:0] pre_r;
	logic [1:0] pre_nxt;
	logic tick_nxt;
	logic src;

	always_comb
	begin
		sync1_nxt = {i_lp_osc, i_irc_osc};
		sync2_nxt = sync1_r;
		src = i_sel ? sync2_r[1] : sync2_r[0];
		prev_nxt = src;
		pre_nxt = pre_r;
		tick_nxt = 1'b0;
		if (src && !prev_r)
		begin
			pre_nxt = pre_r + 2'h1;
			tick_nxt = (pre_r == wsm_pkg::WSM_PRESCALE_LAST);
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			sync1_r <= 2'h0;
			sync2_r <= 2'h0;
			prev_r <= 1'b0;
			pre_r <= 2'h0;
			o_tick <= 1'b0;
		end
		else if (i_ce)
		begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
			prev_r <= prev_nxt;
			pre_r <= pre_nxt;
			o_tick <= tick_nxt;
		end
	end

	default clocking cb_tick @(posedge i_mclk);
	endclocking
	default disable iff (i_reset);

	// An oscillator edge needs two cycles, so four of them span at least eight
	property p_prescale_gap;
		i_ce && o_tick |=> !o_tick [*3];
	endproperty
	a_prescale_gap: assert property (p_prescale_gap) else $error("tick spacing too short");
endmodule

/* dv/wsm_core_tb_top.sv */
// Self-checking testbench of the windowed service monitor
`timescale 1ns/1ps
module wsm_core_tb_top;
	localparam logic [7:0] A_CTRL = wsm_pkg::WSM_OFF_CTRL;
	localparam logic [7:0] A_TO = wsm_pkg::WSM_OFF_TIMEOUT;
	localparam logic [7:0] A_FEED = wsm_pkg::WSM_OFF_FEED;
	localparam logic [7:0] A_CNT = wsm_pkg::WSM_OFF_COUNT;
	localparam logic [7:0] A_STAT = wsm_pkg::WSM_OFF_STATUS;
	localparam logic [7:0] A_MASK = wsm_pkg::WSM_OFF_MASK;
	localparam logic [7:0] A_WARN = wsm_pkg::WSM_OFF_WARN;
	localparam logic [7:0] A_WIN = wsm_pkg::WSM_OFF_WINDOW;
	logic i_mclk, i_reset, i_ce, i_irc_osc, i_lp_osc, i_psel, i_penable, i_pwrite;
	logic [7:0] i_paddr;
	logic [31:0] i_pwdata, o_prdata, rdata;
	logic o_pready, o_pslverr, o_irq, o_chip_reset, rerr;
	int fails = 0;
	int checked = 0;
	int rst_cnt = 0;

	wsm_core #(.CW(wsm_pkg::WSM_CW)) i_wsm_core (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(i_ce),
		.i_irc_osc(i_irc_osc), .i_lp_osc(i_lp_osc), .i_psel(i_psel), .i_penable(i_penable),
		.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
		.o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq), .o_chip_reset(o_chip_reset));

	initial
	begin
		i_mclk = 1'b0;
		forever #10 i_mclk = ~i_mclk;
	end

	// Chip reset is only counted; the block is not reset by it
	always @(posedge i_mclk)
		if (o_chip_reset === 1'b1)
			rst_cnt <= rst_cnt + 1;

	task end_of_test;
		if (fails == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One transfer, then an idle cycle so psel is never driven twice in one step
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_mclk);
		i_penable <= 1'b1;
		@(posedge i_mclk);
		while (o_pready !== 1'b1 && n < 16)
		begin
			@(posedge i_mclk);
			n++;
		end
		rdata = o_prdata;
		rerr = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		if (n == 16)
		begin
			fails++;
			end_of_test;
		end
		@(posedge i_mclk);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		cmp(rdata, exp);
	endtask

	// The irq output follows one cycle after the causing edge
	task chk_irq(input logic exp);
		@(posedge i_mclk);
		cmp({31'h0, o_irq}, {31'h0, exp});
	endtask

	task osc(input logic lp, input int n);
		repeat (n)
		begin
			if (lp)
				i_lp_osc <= 1'b1;
			else
				i_irc_osc <= 1'b1;
			repeat (2) @(posedge i_mclk);
			i_lp_osc <= 1'b0;
			i_irc_osc <= 1'b0;
			repeat (2) @(posedge i_mclk);
		end
		repeat (6) @(posedge i_mclk);
	endtask

	task feed;
		wr(A_FEED, {24'h0, wsm_pkg::WSM_FEED_KEY1});
		wr(A_FEED, {24'h0, wsm_pkg::WSM_FEED_KEY2});
	endtask

	task do_reset;
		i_reset <= 1'b1;
		repeat (12) @(posedge i_mclk);
		i_reset <= 1'b0;
		@(posedge i_mclk);
		rst_cnt = 0;
	endtask

	task t_regs;
		do_reset;
		rd(A_CTRL, 32'h0);
		rd(A_TO, 32'hff);
		rd(A_WIN, 32'hffffff);
		rd(A_CNT, 32'hff);
		rd(A_STAT, 32'h0);
		rd(A_MASK, 32'h0);
		rd(A_WARN, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		cmp(rdata, 32'h0);
		cmp({31'h0, rerr}, 32'h1);
		wr(A_TO, 32'h10);
		rd(A_TO, 32'hff);
	endtask

	task t_feed;
		do_reset;
		wr(A_TO, 32'h300);
		wr(A_CTRL, 32'h3);
		rd(A_CNT, 32'h300);
		// Write the enable bit as zero and keep reset-on-fault; enable stays set, so the later bad feed still resets the chip
		wr(A_CTRL, 32'h2);
		rd(A_CTRL, 32'h3);
		osc(1'b0, 8);
		rd(A_CNT, 32'h2fe);
		feed;
		rd(A_CNT, 32'h300);
		wr(A_FEED, 32'h12);
		rd(A_STAT, 32'h4);
		cmp(rst_cnt, 32'h1);
		rd(A_CTRL, 32'h2);
	endtask

	task t_window;
		do_reset;
		wr(A_TO, 32'h300);
		wr(A_WIN, 32'h2ff);
		wr(A_MASK, 32'h2);
		wr(A_CTRL, 32'h7);
		feed;
		rd(A_STAT, 32'h4);
		cmp(rst_cnt, 32'h1);
		wr(A_STAT, 32'h4);
		wr(A_CTRL, 32'h7);
		osc(1'b0, 4);
		rd(A_CNT, 32'h2ff);
		feed;
		rd(A_CNT, 32'h300);
		cmp(rst_cnt, 32'h1);
		wr(A_CTRL, 32'h1);
		chk_irq(1'b0);
		wr(A_FEED, 32'h55);
		rd(A_STAT, 32'h2);
		chk_irq(1'b1);
		cmp(rst_cnt, 32'h1);
		wr(A_MASK, 32'h0);
		chk_irq(1'b0);
		wr(A_MASK, 32'h2);
		chk_irq(1'b1);
		wr(A_STAT, 32'h2);
		chk_irq(1'b0);
		rd(A_STAT, 32'h0);
	endtask

	task t_timeout;
		do_reset;
		wr(A_WARN, 32'hfb);
		wr(A_MASK, 32'h1);
		wr(A_CTRL, 32'hb);
		osc(1'b0, 12);
		rd(A_CNT, 32'hfc);
		rd(A_STAT, 32'h0);
		osc(1'b0, 4);
		rd(A_STAT, 32'h1);
		chk_irq(1'b1);
		osc(1'b0, 1004);
		rd(A_CNT, 32'h0);
		cmp(rst_cnt, 32'h0);
		osc(1'b0, 4);
		rd(A_STAT, 32'h5);
		cmp(rst_cnt, 32'h1);
		rd(A_CTRL, 32'ha);
	endtask

	task t_sel;
		do_reset;
		wr(A_CTRL, 32'h11);
		osc(1'b0, 8);
		rd(A_CNT, 32'hff);
		osc(1'b1, 8);
		rd(A_CNT, 32'hfd);
		// With the clock enable low, oscillator edges must be lost and the count must hold
		i_ce <= 1'b0;
		osc(1'b1, 8);
		i_ce <= 1'b1;
		rd(A_CNT, 32'hfd);
	endtask

	initial
	begin
		i_reset = 1'b1;
		i_ce = 1'b1;
		i_irc_osc = 1'b0;
		i_lp_osc = 1'b0;
		i_psel = 1'b0;
		i_penable = 1'b0;
		i_pwrite = 1'b0;
		i_paddr = 8'h0;
		i_pwdata = 32'h0;
		t_regs;
		t_feed;
		t_window;
		t_timeout;
		t_sel;
		end_of_test;
	end
endmodule

/* pkg/wsm_pkg.sv */
// Constants and carrier types of the windowed service monitor
package wsm_pkg;
	localparam int unsigned WSM_AW = 8;
	localparam int unsigned WSM_CW = 24;
	localparam logic [7:0] WSM_OFF_CTRL = 8'h00;
	localparam logic [7:0] WSM_OFF_TIMEOUT = 8'h04;
	localparam logic [7:0] WSM_OFF_FEED = 8'h08;
	localparam logic [7:0] WSM_OFF_COUNT = 8'h0c;
	localparam logic [7:0] WSM_OFF_STATUS = 8'h10;
	localparam logic [7:0] WSM_OFF_MASK = 8'h14;
	localparam logic [7:0] WSM_OFF_WARN = 8'h18;
	localparam logic [7:0] WSM_OFF_WINDOW = 8'h1c;
	localparam int unsigned WSM_CTRL_W = 5;
	localparam int unsigned WSM_EVT_W = 3;
	localparam logic [7:0] WSM_FEED_KEY1 = 8'haa;
	localparam logic [7:0] WSM_FEED_KEY2 = 8'h55;
	localparam logic [23:0] WSM_TIMEOUT_MIN = 24'h0000ff;
	localparam logic [23:0] WSM_TIMEOUT_RST = 24'h0000ff;
	localparam logic [23:0] WSM_WARN_RST = 24'h000000;
	localparam logic [23:0] WSM_WINDOW_RST = 24'hffffff;
	localparam logic [1:0] WSM_PRESCALE_LAST = 2'h3;
	localparam logic [2:0] WSM_MASK_RST = 3'h0;

	// Control fields, bit 0 upward: enable, reset on fault, window, warning, clock select
	typedef struct packed {
		logic clk_sel;
		logic warn_en;
		logic win_en;
		logic rst_en;
		logic en;
	} wsm_ctrl_t;

	// Sticky events, bit 0 upward: warning, fault interrupt, watchdog caused reset
	typedef struct packed {
		logic rst_flag;
		logic fault;
		logic warn;
	} wsm_evt_t;
endpackage
